// ---- tdpc_core.sv ----
// Terminal Doppler precompensation: burst filtering, drift, corrections
`timescale 1ns/1ps

// Functional notes
// - Each accepted burst updates carrier and chip corrections and offset; drift only once the window was already full.
// - Offsets are taken from any ground station as one source.
// - Offsets are window averaged; drift derived; offset predicted forward in time.
// - Doppler ppm is one million times predicted offset over forward carrier.
// - Corrections are minus ppm over one million times return carrier or chip.
// - Bursts failing CRC are ignored for corrections.
// - Bursts flagged unfit for precompensation leave the estimate alone unless their reset toggle changed, and still restart the loss timer.
// - Corrections are driven to the transmitter every cycle.
// - Prediction keeps ramping with drift while transmitting.
// - A changed reset toggle in the descriptor resets the instance.
// - No good burst within the loss timeout halts transmission.
// - Transmission halts while no Doppler estimate is available.
// - Transmission resumes only once nominal operation returns.
// - Reception runs continuously until the terminal logs out.
// - Two independent instances run in parallel during handover.
// - Each transmitted burst uses the corrections of its own carrier.
// - Two forward carriers are received with separate corrections.
module tdpc_core
    import tdpc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic logged_in,
    input wire tdpc_burst_type burst,
    input wire tdpc_cfg_type cfg,
    input wire logic tx_sel,
    output logic [CORR_W-1:0] tx_carrier_corr,
    output logic [CORR_W-1:0] tx_chip_corr,
    output logic tx_allowed,
    output logic [NUM_INST-1:0] inst_tx_ok
);

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    // Mean of the offset window, Q8 Hz
    function automatic logic [OFF_W-1:0] avg4(input logic [WIN_LEN-1:0][OFF_W-1:0] w);
        logic signed [OFF_W+1:0] s;
        s = '0;
        for (int k = 0; k < WIN_LEN; k++)
        begin
            s = s + (OFF_W+2)'($signed(w[k]));
        end
        return OFF_W'(s >>> WIN_SHIFT);
    endfunction : avg4

    // Index of the highest set bit; interval rounded down to a power of two
    function automatic logic [3:0] msb16(input logic [TMR_W-1:0] v);
        logic [3:0] m;
        m = 4'h0;
        for (int k = 0; k < TMR_W; k++)
        begin
            if (v[k])
            begin
                m = 4'(k);
            end
        end
        return m;
    endfunction : msb16

    // Offset in Hz Q16 to a transmit correction in Hz Q8
    function automatic logic [CORR_W-1:0] corr(
        input logic [PRED_W-1:0] pred,
        input logic [NOM_W-1:0] scale,
        input logic [NOM_W-1:0] nom
    );
        logic signed [63:0] ppm;
        logic signed [95:0] t;
        ppm = ($signed(pred) * $signed({1'b0, scale})) >>> PPM_ALIGN;
        t = ppm * $signed({1'b0, nom});
        t = (t * $signed({1'b0, MEGA_RECIP})) >>> CORR_ALIGN;
        return CORR_W'(-t);
    endfunction : corr

    ////////////////////////////////////////////////////////////////////////
    // State and tick

    tdpc_state_type state_reg;
    tdpc_state_type state_next;
    logic tick;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

    // Tick ends each millisecond
    assign tick = (state_reg.tick_cnt == TICK_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Per-instance estimation; instance index follows the burst carrier
    always_comb
    begin
        logic good;
        logic [OFF_W-1:0] avg;
        logic [PRED_W-1:0] delta;
        state_next = state_reg;
        good = 1'b0;
        avg = '0;
        delta = '0;
        state_next.tick_cnt = tick ? '0 : state_reg.tick_cnt + 20'h1;
        for (int i = 0; i < NUM_INST; i++)
        begin
            // Origin of the burst is not looked at
            good = burst.valid && burst.carrier == 1'(i) && burst.crc_ok;
            if (tick)
            begin
                // Prediction keeps moving between bursts
                state_next.inst[i].pred = state_reg.inst[i].pred + state_reg.inst[i].drift;
                if (state_reg.inst[i].idle != 16'hffff)
                begin
                    state_next.inst[i].idle = state_reg.inst[i].idle + 16'h1;
                end
                if (state_reg.inst[i].since != 16'hffff)
                begin
                    state_next.inst[i].since = state_reg.inst[i].since + 16'h1;
                end
            end
            if (good)
            begin
                state_next.inst[i].idle = '0;
                // Corrupt descriptors never reach the toggle
                if (state_reg.inst[i].toggle_seen &&
                    burst.reset_toggle != state_reg.inst[i].toggle)
                begin
                    state_next.inst[i].win = '0;
                    state_next.inst[i].wptr = '0;
                    state_next.inst[i].fill = '0;
                    state_next.inst[i].last_avg = '0;
                    state_next.inst[i].drift = '0;
                    state_next.inst[i].pred = '0;
                    state_next.inst[i].since = '0;
                end
                state_next.inst[i].toggle = burst.reset_toggle;
                state_next.inst[i].toggle_seen = 1'b1;
            end
            // Only accepted bursts load the estimate; a toggle change above clears it on any good burst
            if (good && burst.suitable)
            begin
                state_next.inst[i].win[state_next.inst[i].wptr] = burst.offset;
                state_next.inst[i].wptr = state_next.inst[i].wptr + 2'h1;
                if (state_next.inst[i].fill != WIN_FULL)
                begin
                    state_next.inst[i].fill = state_next.inst[i].fill + 3'h1;
                end
                avg = avg4(state_next.inst[i].win);
                // Drift needs two full windows; power-of-two interval trades accuracy
                if (state_reg.inst[i].fill == WIN_FULL && state_next.inst[i].fill == WIN_FULL)
                begin
                    delta = PRED_W'($signed(avg) - $signed(state_reg.inst[i].last_avg));
                    delta = delta <<< PRED_FRAC_SHIFT;
                    state_next.inst[i].drift =
                        PRED_W'($signed(delta) >>> msb16(state_reg.inst[i].since));
                end
                state_next.inst[i].last_avg = avg;
                state_next.inst[i].pred = PRED_W'($signed(avg)) <<< PRED_FRAC_SHIFT;
                state_next.inst[i].since = '0;
            end
            // Logging out drops all synchronisation
            if (!logged_in)
            begin
                state_next.inst[i] = '0;
            end
            state_next.inst[i].ok = logged_in &&
                state_next.inst[i].fill == WIN_FULL &&
                state_next.inst[i].idle < cfg.carrier_loss_timeout;
        end
        // Corrections of the carrier in use, refreshed every cycle
        state_next.carr_corr = corr(state_reg.inst[tx_sel].pred, cfg.fwd_ppm_scale[tx_sel],
                                    cfg.rtn_carrier_hz[tx_sel]);
        state_next.chip_corr = corr(state_reg.inst[tx_sel].pred, cfg.fwd_ppm_scale[tx_sel],
                                    cfg.rtn_chip_hz[tx_sel]);
        state_next.tx_allowed = state_reg.inst[tx_sel].ok;
    end

    // State register; clock enable freezes everything
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign tx_carrier_corr = state_reg.carr_corr;
    assign tx_chip_corr = state_reg.chip_corr;
    assign tx_allowed = state_reg.tx_allowed;
    assign inst_tx_ok = {state_reg.inst[1].ok, state_reg.inst[0].ok};

    ////////////////////////////////////////////////////////////////////////
    // Checks on instance 0, carrier selection and transmit after logout

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence own_s;
        ce && logged_in && burst.valid && !burst.carrier;
    endsequence

    sequence bad_crc_s;
        own_s and !burst.crc_ok;
    endsequence

    sequence unfit_s;
        own_s and burst.crc_ok && !burst.suitable;
    endsequence

    sequence keep_toggle_s;
        burst.reset_toggle == state_reg.inst[0].toggle;
    endsequence

    crc_drop_a: assert property (bad_crc_s |=> $stable(state_reg.inst[0].win)
        && $stable(state_reg.inst[0].fill))
        else $error("bad crc burst changed window");

    unfit_drop_a: assert property ((unfit_s and keep_toggle_s) |=>
        $stable(state_reg.inst[0].win) && state_reg.inst[0].idle == 16'h0)
        else $error("unfit burst used or not seen");

    hold_estimate_a: assert property (((bad_crc_s or (unfit_s and keep_toggle_s))
        and !tick) |=> $stable(state_reg.inst[0].pred) && $stable(state_reg.inst[0].last_avg))
        else $error("discarded burst moved estimate");

    accept_burst_a: assert property ((own_s and burst.crc_ok && burst.suitable) |=>
        state_reg.inst[0].pred == PRED_W'($signed(state_reg.inst[0].last_avg)) <<< PRED_FRAC_SHIFT
        && state_reg.inst[0].since == 16'h0)
        else $error("accepted burst not loaded");

    toggle_reset_a: assert property ((own_s and burst.crc_ok &&
        state_reg.inst[0].toggle_seen && !(burst.reset_toggle == state_reg.inst[0].toggle))
        |=> state_reg.inst[0].fill <= 3'h1)
        else $error("toggle change did not reset");

    drift_ramp_a: assert property (ce && tick && logged_in &&
        !(burst.valid && !burst.carrier) |=>
        state_reg.inst[0].pred == $past(state_reg.inst[0].pred) + $past(state_reg.inst[0].drift))
        else $error("prediction did not follow drift");

    loss_halt_a: assert property (ce && !(burst.valid && !burst.carrier) &&
        state_reg.inst[0].idle >= cfg.carrier_loss_timeout |=> !state_reg.inst[0].ok)
        else $error("carrier loss did not halt");

    est_halt_a: assert property (ce && state_reg.inst[0].fill < 3'h3 |=>
        !state_reg.inst[0].ok)
        else $error("halt missing without estimate");

    resume_a: assert property ($rose(state_reg.inst[0].ok) |->
        state_reg.inst[0].fill == WIN_FULL && state_reg.inst[0].idle < cfg.carrier_loss_timeout)
        else $error("resumed without nominal state");

    select_a: assert property (ce |=> state_reg.tx_allowed ==
        $past(state_reg.inst[tx_sel].ok))
        else $error("wrong carrier selected");

    logout_a: assert property (ce && !logged_in ##1 ce |=> !state_reg.tx_allowed)
        else $error("transmit allowed after logout");

    ////////////////////////////////////////////////////////////////////////
    // Checks on instance 1, logout and clock enable

    sequence other_s;
        ce && logged_in && burst.valid && burst.carrier;
    endsequence

    other_inst_a: assert property (other_s |=> $stable(state_reg.inst[0].win)
        && $stable(state_reg.inst[0].fill))
        else $error("second carrier burst touched first instance");

    inst1_crc_a: assert property ((other_s and !burst.crc_ok) |=>
        $stable(state_reg.inst[1].win) && $stable(state_reg.inst[1].fill))
        else $error("bad crc burst changed second window");

    inst1_loss_a: assert property (ce && !(burst.valid && burst.carrier) &&
        state_reg.inst[1].idle >= cfg.carrier_loss_timeout |=> !state_reg.inst[1].ok)
        else $error("second carrier loss did not halt");

    logout_clear_a: assert property (ce && !logged_in |=>
        state_reg.inst[0].fill == 3'h0 && state_reg.inst[1].fill == 3'h0 && inst_tx_ok == 2'h0)
        else $error("logout left an instance running");

    // Frozen clock enable must not let the prediction ramp on its own
    freeze_hold_a: assert property (!ce |=> $stable(state_reg))
        else $error("state moved while clock enable low");

endmodule : tdpc_core

// ---- tdpc_pkg.sv ----
// Constants and carrier types for the terminal Doppler precompensation block
package tdpc_pkg;

    // Offsets and corrections in Hz, Q8; prediction in Hz, Q16
    localparam int OFF_W = 24;
    localparam int PRED_W = 32;
    localparam int CORR_W = 32;
    localparam int NOM_W = 32;
    localparam int TMR_W = 16;
    localparam int NUM_INST = 2;

    // Sliding window of accepted offsets
    localparam int WIN_LEN = 4;
    localparam int WIN_SHIFT = 2;
    localparam logic [2:0] WIN_FULL = 3'h4;
    localparam int PRED_FRAC_SHIFT = 8;

    // Millisecond tick for drift and carrier loss timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 20;

    // Recommended carrier loss timeout, seconds, and as ms for the port
    localparam int LOSS_TIMEOUT_S = 5;
    localparam logic [TMR_W-1:0] LOSS_TIMEOUT_MS_DEF = 16'h1388;

    // Ppm arithmetic: scale input is 1e6 * 2^32 / nominal forward carrier
    localparam int PPM_MEGA = 1000000;
    localparam int PPM_ALIGN = 24;
    localparam logic [20:0] MEGA_RECIP = 21'h10c6f8;
    localparam int CORR_ALIGN = 56;

    typedef struct packed {
        logic valid;
        logic carrier;
        logic crc_ok;
        logic suitable;
        logic reset_toggle;
        logic [OFF_W-1:0] offset;
    } tdpc_burst_type;

    typedef struct packed {
        logic [NUM_INST-1:0][NOM_W-1:0] fwd_ppm_scale;
        logic [NUM_INST-1:0][NOM_W-1:0] rtn_carrier_hz;
        logic [NUM_INST-1:0][NOM_W-1:0] rtn_chip_hz;
        logic [TMR_W-1:0] carrier_loss_timeout;
    } tdpc_cfg_type;

    typedef struct packed {
        logic [WIN_LEN-1:0][OFF_W-1:0] win;
        logic [WIN_SHIFT-1:0] wptr;
        logic [2:0] fill;
        logic [OFF_W-1:0] last_avg;
        logic [PRED_W-1:0] drift;
        logic [PRED_W-1:0] pred;
        logic [TMR_W-1:0] since;
        logic [TMR_W-1:0] idle;
        logic toggle;
        logic toggle_seen;
        logic ok;
    } tdpc_inst_type;

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        tdpc_inst_type [NUM_INST-1:0] inst;
        logic [CORR_W-1:0] carr_corr;
        logic [CORR_W-1:0] chip_corr;
        logic tx_allowed;
    } tdpc_state_type;

endpackage : tdpc_pkg

// ---- tdpc_rx_model.sv ----
// Behavioural forward burst receiver feeding the precompensation core
`timescale 1ns/1ps
module tdpc_rx_model
    import tdpc_pkg::*;
(
    input wire logic mclk,
    output tdpc_burst_type burst
);
    logic toggle_reg;

    ////////////////////////////////////////////////////////////////////////
    // Idle group at time zero
    initial
    begin
        burst = '0;
        toggle_reg = 1'b0;
    end

    // Bulk handover: ground side flips the descriptor toggle
    task flip_toggle;
        toggle_reg = ~toggle_reg;
    endtask : flip_toggle

    // One burst for one cycle; offset scrambled after so stale data never passes
    task send(input logic car, input logic crc, input logic fit, input logic [OFF_W-1:0] off);
        @(posedge mclk);
        #1;
        burst.valid = 1'b1;
        burst.carrier = car;
        burst.crc_ok = crc;
        burst.suitable = fit;
        burst.reset_toggle = toggle_reg;
        burst.offset = off;
        @(posedge mclk);
        #1;
        burst.valid = 1'b0;
        burst.offset = ~off;
    endtask : send
endmodule : tdpc_rx_model

// ---- terminal_doppler_precompensation_tb.sv ----
// Self-checking bench for the terminal Doppler precompensation core
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
        fail_count++; \
        $display("BAD %s exp %h got %h", nm, ex, gt); \
    end
module terminal_doppler_precompensation_tb;
    import tdpc_pkg::*;
    // Short tick keeps the loss timeout within a short run
    localparam int TK = 10;
    localparam logic [OFF_W-1:0] O0 = 24'h006400;
    localparam logic [OFF_W-1:0] O1 = 24'hffce00;
    logic mclk, sys_rst, ce, logged_in, tx_sel;
    tdpc_burst_type burst;
    tdpc_cfg_type cfg;
    logic [CORR_W-1:0] carr, chip, held;
    logic tx_allowed;
    logic [NUM_INST-1:0] ok;
    int fail_count, cmp_count;

    tdpc_core #(.TICK_CYCLES_P(TK)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .logged_in(logged_in), .burst(burst),
        .cfg(cfg), .tx_sel(tx_sel), .tx_carrier_corr(carr), .tx_chip_corr(chip),
        .tx_allowed(tx_allowed), .inst_tx_ok(ok)
    );
    tdpc_rx_model rx (.mclk(mclk), .burst(burst));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Expected correction from a full window of one offset, wide enough for no overflow
    function logic [CORR_W-1:0] exp_corr(input logic [OFF_W-1:0] off,
        input logic [NOM_W-1:0] sc, input logic [NOM_W-1:0] nm);
        logic signed [127:0] v;
        v = $signed({{104{off[OFF_W-1]}}, off}) <<< 8;
        v = (v * $signed({96'h0, sc})) >>> 24;
        v = (v * $signed({96'h0, nm}) * 128'sd1099512) >>> 56;
        return CORR_W'(-v);
    endfunction : exp_corr

    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task fill(input logic c, input logic [OFF_W-1:0] off, input int n);
        repeat (n) rx.send(c, 1'b1, 1'b1, off);
    endtask : fill

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end

    // Test sequence
    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        logged_in = 1'b1;
        tx_sel = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        cfg = '0;
        cfg.fwd_ppm_scale[0] = 32'h002bb0cf;
        cfg.fwd_ppm_scale[1] = 32'h00271c72;
        cfg.rtn_carrier_hz[0] = 32'h5f5e1000;
        cfg.rtn_carrier_hz[1] = 32'h60d6d100;
        cfg.rtn_chip_hz[0] = 32'h003a9800;
        cfg.rtn_chip_hz[1] = 32'h001e8480;
        cfg.carrier_loss_timeout = 16'h0014;
        cyc(5);
        sys_rst = 1'b0;
        `CHK("tx_allowed rst", 1'b0, tx_allowed)
        // Window must fill before transmission is allowed
        fill(1'b0, O0, 3);
        `CHK("ok three", 2'b00, ok)
        fill(1'b0, O0, 1);
        `CHK("ok four", 2'b01, ok)
        cyc(3);
        `CHK("tx_allowed", 1'b1, tx_allowed)
        `CHK("carr corr", exp_corr(O0, cfg.fwd_ppm_scale[0], cfg.rtn_carrier_hz[0]), carr)
        `CHK("chip corr", exp_corr(O0, cfg.fwd_ppm_scale[0], cfg.rtn_chip_hz[0]), chip)
        $display("test window done");
        // Bad CRC and unfit bursts leave the corrections alone
        held = carr;
        rx.send(1'b0, 1'b0, 1'b1, 24'h7fff00);
        cyc(3);
        `CHK("crc discard", held, carr)
        rx.send(1'b0, 1'b1, 1'b0, 24'h800100);
        cyc(3);
        `CHK("unfit discard", held, carr)
        `CHK("chip held", exp_corr(O0, cfg.fwd_ppm_scale[0], cfg.rtn_chip_hz[0]), chip)
        $display("test discard done");
        // Second carrier gets its own corrections, picked per burst by tx_sel
        fill(1'b1, O1, 4);
        `CHK("both ok", 2'b11, ok)
        tx_sel = 1'b1;
        cyc(3);
        `CHK("i1 corr", exp_corr(O1, cfg.fwd_ppm_scale[1], cfg.rtn_carrier_hz[1]), carr)
        rx.send(1'b1, 1'b0, 1'b1, 24'h7fff00);
        cyc(3);
        `CHK("i1 crc", exp_corr(O1, cfg.fwd_ppm_scale[1], cfg.rtn_carrier_hz[1]), carr)
        tx_sel = 1'b0;
        cyc(3);
        `CHK("i0 again", exp_corr(O0, cfg.fwd_ppm_scale[0], cfg.rtn_carrier_hz[0]), carr)
        $display("test dual done");
        // Carrier loss after 20 ticks without a good burst, then recovery
        rx.send(1'b0, 1'b1, 1'b1, O0);
        cyc(15 * TK);
        `CHK("ok before loss", 1'b1, ok[0])
        cyc(8 * TK);
        `CHK("ok lost", 2'b00, ok)
        `CHK("tx halted", 1'b0, tx_allowed)
        rx.send(1'b0, 1'b1, 1'b1, O0);
        `CHK("ok resumed", 1'b1, ok[0])
        $display("test loss done");
        // Toggle change restarts the estimate of that instance
        rx.flip_toggle();
        rx.send(1'b0, 1'b1, 1'b1, O0);
        `CHK("toggle reset", 1'b0, ok[0])
        fill(1'b0, O0, 3);
        `CHK("toggle refill", 1'b1, ok[0])
        $display("test toggle done");
        // A changed offset gives drift; prediction keeps moving between bursts
        rx.send(1'b0, 1'b1, 1'b1, 24'h006c00);
        cyc(3);
        held = carr;
        cyc(3 * TK);
        // Rising offset means a correction that keeps falling
        `CHK("drift ramp", 1'b1, $signed(carr) < $signed(held))
        held = carr;
        cyc(3 * TK);
        `CHK("drift keeps", 1'b1, $signed(carr) < $signed(held))
        // Clock enable low freezes the ramp as well
        ce = 1'b0;
        held = carr;
        cyc(3 * TK);
        `CHK("ce freeze", held, carr)
        ce = 1'b1;
        $display("test drift done");
        // Logging out clears both instances
        logged_in = 1'b0;
        cyc(3);
        `CHK("logout ok", 2'b00, ok)
        `CHK("logout tx", 1'b0, tx_allowed)
        logged_in = 1'b1;
        $display("test logout done");
        // Reset in mid-run clears a running instance; first burst after it starts afresh
        tx_sel = 1'b1;
        fill(1'b1, O1, 4);
        cyc(2);
        `CHK("pre reset ok", 2'b10, ok)
        `CHK("pre reset tx", 1'b1, tx_allowed)
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        `CHK("reset ok", 2'b00, ok)
        `CHK("reset tx", 1'b0, tx_allowed)
        `CHK("reset corr", 32'h0, carr)
        fill(1'b0, O0, 1);
        `CHK("reset refill", 2'b00, ok)
        $display("test reset done");
        tally_and_finish();
    end
endmodule : terminal_doppler_precompensation_tb
